/* verif/nvmac_asserts.sv */
`timescale 1ns/1ps
`include "nvmac_params.svh"
`default_nettype none
module nvmac_asserts (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	// bus
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic I_HREADY,
	input wire logic [31:0] O_HRDATA,
	input wire logic O_HREADYOUT,
	input wire logic O_HRESP,
	input wire logic O_IRQ
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	wire logic taken = I_HSEL & I_HTRANS[1] & I_HREADY;
	// read of one register, ending where its data stands
	sequence s_rd(logic [5:0] idx);
		taken && !I_HWRITE && I_HADDR == {24'h000000, idx, 2'h0} ##2 O_HREADYOUT;
	endsequence
	a_resp_okay: assert property (O_HRESP == 1'h0)
		else $error("error response seen");
	a_read_wait: assert property (taken && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
		else $error("read wait state wrong");
	a_write_nowait: assert property (taken && I_HWRITE |=> O_HREADYOUT)
		else $error("write stalled");
	a_ctrl_spare_zero: assert property (
		s_rd(`NVMAC_IDX_CONTROL) |-> O_HRDATA[2:0] == 3'h0 && O_HRDATA[31:8] == 24'h000000)
		else $error("control spare bits set");
	a_addr_top_zero: assert property (
		s_rd(`NVMAC_IDX_BYTE_ADDRESS) |-> O_HRDATA[31:7] == 25'h0000000)
		else $error("address top bit set");
	a_data_byte: assert property (s_rd(`NVMAC_IDX_BYTE_DATA) |-> O_HRDATA[31:8] == 24'h000000)
		else $error("data wider than a byte");
	a_done_busy: assert property (
		s_rd(`NVMAC_IDX_CONTROL) |-> !O_HRDATA[4] || O_HRDATA[6])
		else $error("done flag without write");
	a_reset_quiet: assert property ($rose(I_NRST) |-> !O_IRQ && O_HREADYOUT)
		else $error("outputs busy after reset");
endmodule
`default_nettype wire

/* verif/nvmac_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module nvmac_bench;
	logic clk;
	logic nrst;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	int errors = 0;
	int n_checks = 0;
	nvmac_top dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
		.I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
		.O_HRESP(hresp), .O_IRQ(irq));
	nvmac_cpu_model cpu (.i_clk(clk), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
		.o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata), .i_hready(hreadyout),
		.i_hrdata(hrdata));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		if (errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_reset;
		logic [7:0] r;
		for (int i = 0; i < 5; i++) begin
			cpu.rd(cpu.a_ctl + 32'(4 * i), r);
			check("reset value", r, 8'h00);
		end
	endtask
	task automatic t_fields;
		logic [7:0] r;
		cpu.wr(cpu.a_adr, 8'hFF);
		cpu.rd(cpu.a_adr, r);
		check("address", r, 8'h7F);
		cpu.wr_narrow(cpu.a_adr, 8'h11);
		cpu.rd(cpu.a_adr, r);
		check("narrow write", r, 8'h7F);
		cpu.wr(cpu.a_ctl, 8'h2F);
		cpu.rd(cpu.a_ctl, r);
		check("control", r, 8'h28);
		cpu.rd(32'h00000100, r);
		check("unmapped", r, 8'h00);
	endtask
	// same byte rewritten with complementary bits shows the erase
	task automatic t_write;
		logic [6:0] at [3] = '{7'h00, 7'h7F, 7'h00};
		logic [7:0] dv [3] = '{8'h55, 8'h3C, 8'hAA};
		logic sd, ok;
		logic [7:0] r;
		for (int i = 0; i < 3; i++) begin
			cpu.program_byte(at[i], dv[i], 1'b1, sd, ok);
			check("done seen", {7'h0, sd}, 8'h01);
			check("write ends", {7'h0, ok}, 8'h01);
			cpu.fetch_byte(at[i], r, ok);
			check("read ends", {7'h0, ok}, 8'h01);
			check("byte", r, dv[i]);
		end
	endtask
	task automatic t_refuse;
		logic sd, ok;
		logic [7:0] r;
		cpu.rd(cpu.a_sts, r);
		cpu.program_byte(7'h00, 8'h00, 1'b0, sd, ok);
		check("no done", {7'h0, sd}, 8'h00);
		cpu.fetch_byte(7'h00, r, ok);
		check("kept", r, 8'hAA);
		cpu.rd(cpu.a_sts, r);
		check("status", r, 8'h05);
	endtask
	task automatic t_power;
		logic sd, ok;
		logic [7:0] r;
		cpu.wr(cpu.a_adr, 8'h7F);
		cpu.wr(cpu.a_ctl, 8'h80);
		cpu.wait_idle(sd, ok);
		cpu.rd(cpu.a_ctl, r);
		check("request dropped", r, 8'h00);
		cpu.rd(cpu.a_dat, r);
		check("data unchanged", r, 8'hAA);
		#1;
		check("irq masked", {7'h0, irq}, 8'h00);
		cpu.wr(cpu.a_msk, 8'h08);
		#1;
		check("irq up", {7'h0, irq}, 8'h01);
		cpu.rd(cpu.a_sts, r);
		#1;
		check("status", r, 8'h08);
		check("irq cleared", {7'h0, irq}, 8'h00);
		cpu.wr(cpu.a_msk, 8'h00);
		cpu.wr(cpu.a_ctl, 8'h00);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// the whole sequence needs a few hundred cycles
	initial begin
		#2000000;
		errors++;
		summarize;
	end
	initial begin
		nrst = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_fields;
		t_write;
		t_refuse;
		t_power;
		summarize;
	end
endmodule
bind nvmac_top nvmac_asserts chk (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_HSEL(I_HSEL),
	.I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
	.O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ));
`default_nettype wire

/* verif/nvmac_cpu_model.sv */
`timescale 1ns/1ps
`include "nvmac_params.svh"
`default_nettype none
module nvmac_cpu_model (
	// clock
	input wire logic i_clk,
	// bus master
	output logic o_hsel,
	output logic [31:0] o_haddr,
	output logic [1:0] o_htrans,
	output logic o_hwrite,
	output logic [2:0] o_hsize,
	output logic [31:0] o_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] i_hrdata
);
	localparam logic [31:0] a_ctl = {24'h000000, `NVMAC_IDX_CONTROL, 2'h0};
	localparam logic [31:0] a_adr = {24'h000000, `NVMAC_IDX_BYTE_ADDRESS, 2'h0};
	localparam logic [31:0] a_dat = {24'h000000, `NVMAC_IDX_BYTE_DATA, 2'h0};
	localparam logic [31:0] a_sts = {24'h000000, `NVMAC_IDX_IRQ_STATUS, 2'h0};
	localparam logic [31:0] a_msk = {24'h000000, `NVMAC_IDX_IRQ_MASK, 2'h0};
	initial begin
		o_hsel = 1'b0;
		o_haddr = 32'h00000000;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize = 3'h2;
		o_hwdata = 32'h00000000;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
		input logic [2:0] sz, output logic [7:0] r);
		@(posedge i_clk);
		o_hsel <= 1'b1;
		o_htrans <= 2'h2;
		o_haddr <= a;
		o_hwrite <= w;
		o_hsize <= sz;
		do @(posedge i_clk); while (i_hready !== 1'b1);
		o_htrans <= 2'h0;
		o_hwdata <= {24'h000000, d};
		do @(posedge i_clk); while (i_hready !== 1'b1);
		r = i_hrdata[7:0];
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b1, a, d, `NVMAC_HSIZE_WORD, r);
	endtask
	// byte-sized write, which the block must ignore
	task automatic wr_narrow(input logic [31:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b1, a, d, 3'h0, r);
	endtask
	task automatic rd(input logic [31:0] a, output logic [7:0] r);
		xfer(1'b0, a, 8'h00, `NVMAC_HSIZE_WORD, r);
	endtask
	// polls until both requests and the done flag are clear
	task automatic wait_idle(output logic saw_done, output logic ok);
		logic [7:0] v;
		saw_done = 1'b0;
		ok = 1'b0;
		for (int n = 0; n < 60 && !ok; n++) begin
			rd(a_ctl, v);
			saw_done |= v[4];
			ok = (v[7:6] == 2'h0) && !v[4];
		end
	endtask
	task automatic program_byte(input logic [6:0] a, input logic [7:0] d, input logic en,
		output logic saw_done, output logic ok);
		wr(a_ctl, 8'h08);
		wr(a_adr, {1'b0, a});
		wr(a_ctl, {2'h0, en, 5'h08});
		wr(a_dat, d);
		wr(a_ctl, {2'h1, en, 5'h08});
		wait_idle(saw_done, ok);
	endtask
	task automatic fetch_byte(input logic [6:0] a, output logic [7:0] d, output logic ok);
		logic sd;
		wr(a_ctl, 8'h08);
		wr(a_adr, {1'b0, a});
		wr(a_ctl, 8'h88);
		wait_idle(sd, ok);
		rd(a_dat, d);
	endtask
endmodule
`default_nettype wire

/* verilog/nvmac_params.svh */
`ifndef NVMAC_PARAMS_SVH
`define NVMAC_PARAMS_SVH

// register word indices, byte address is four times the index
`define NVMAC_IDX_CONTROL 6'h0B
`define NVMAC_IDX_BYTE_ADDRESS 6'h0C
`define NVMAC_IDX_BYTE_DATA 6'h0D
`define NVMAC_IDX_IRQ_STATUS 6'h0E
`define NVMAC_IDX_IRQ_MASK 6'h0F

// control register field positions
`define NVMAC_BIT_RD_REQ 7
`define NVMAC_BIT_WR_REQ 6
`define NVMAC_BIT_WR_EN 5
`define NVMAC_BIT_DONE 4
`define NVMAC_BIT_PWR 3

// reset values
`define NVMAC_CTRL_RESET 5'h00
`define NVMAC_ADDR_RESET 7'h00
`define NVMAC_DATA_RESET 8'h00
`define NVMAC_IRQ_RESET 4'h0
`define NVMAC_ERASED_BYTE 8'hFF

// bus encodings
`define NVMAC_HTRANS_ACTIVE_BIT 1
`define NVMAC_HSIZE_WORD 3'h2
`define NVMAC_HRESP_OKAY 1'h0

// timing: clock rate in kHz, cell times in ns
`define NVMAC_CLK_KHZ 10000
`define NVMAC_ERASE_NS 2000
`define NVMAC_PROG_NS 2000
`define NVMAC_ERASE_CYC ((`NVMAC_ERASE_NS * `NVMAC_CLK_KHZ + 999999) / 1000000)
`define NVMAC_PROG_CYC ((`NVMAC_PROG_NS * `NVMAC_CLK_KHZ + 999999) / 1000000)
`define NVMAC_READ_CYC 1

`endif

/* verilog/nvmac_pkg.sv */
package nvmac_pkg;

	typedef enum logic [1:0] {
		NVMAC_IDLE,
		NVMAC_READ,
		NVMAC_ERASE,
		NVMAC_PROGRAM
	} nvmac_state_t;

	typedef struct packed {
		logic rd_req;
		logic wr_req;
		logic write_enable_gate;
		logic done_detect;
		logic array_power_on;
	} nvmac_ctrl_t;

	typedef struct packed {
		logic pwr_refused;
		logic wr_refused;
		logic wr_done;
		logic rd_done;
	} nvmac_irq_t;

	typedef struct packed {
		logic in_range;
		logic [5:0] idx;
		logic word;
	} nvmac_req_t;

endpackage

/* verilog/nvmac_top.sv */
// How it works
// - every write erases the addressed byte, then programs the new value
// - address register holds a 7-bit byte address; top bit reads zero
// - setting read request starts a byte read; hardware clears it when done
// - setting write request starts erase-then-write; cleared only when finished or refused
// - write-enable gate at 0 forbids array programming, at 1 allows it
// - done-detect reads 1 while a write cycle runs, 0 once complete
// - power bit 0 refuses new reads and writes; an access already running still completes
// - control bits 2 to 0 always read zero
// - data register holds the byte to program, receives the byte read
// - reads and writes work anytime in normal operation, no special mode
`timescale 1ns/1ps
`include "nvmac_params.svh"
`default_nettype none

module nvmac_top (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	// ahb-lite slave
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	// interrupt
	output logic O_IRQ
);

	function automatic nvmac_pkg::nvmac_req_t decode_req(input logic [31:0] addr,
			input logic [2:0] size);
		nvmac_pkg::nvmac_req_t r;
		r.in_range = (addr[31:8] == 24'h000000) && (addr[1:0] == 2'h0);
		r.idx = addr[7:2];
		r.word = (size == `NVMAC_HSIZE_WORD);
		return r;
	endfunction

	function automatic logic reg_hit(input nvmac_pkg::nvmac_req_t r, input logic [5:0] target);
		return r.in_range && (r.idx == target);
	endfunction

	// bus phase tracking
	logic take;
	logic take_wr;
	logic take_rd;
	logic wr_pend;
	logic rd_pend;
	nvmac_pkg::nvmac_req_t wr_req_ph;
	nvmac_pkg::nvmac_req_t rd_req_ph;

	// register state
	nvmac_pkg::nvmac_ctrl_t ctrl;
	nvmac_pkg::nvmac_ctrl_t next_ctrl;
	logic [6:0] byte_addr;
	logic [6:0] next_byte_addr;
	logic [7:0] byte_data;
	logic [7:0] next_byte_data;
	nvmac_pkg::nvmac_irq_t irq_status;
	nvmac_pkg::nvmac_irq_t next_irq_status;
	nvmac_pkg::nvmac_irq_t irq_mask;
	nvmac_pkg::nvmac_irq_t next_irq_mask;
	nvmac_pkg::nvmac_irq_t events;

	// access engine
	nvmac_pkg::nvmac_state_t state;
	nvmac_pkg::nvmac_state_t next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [6:0] op_addr;
	logic [7:0] op_data;
	logic start_op;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] array_mem [0:127];

	// decoded writes and reads
	logic sw_wr_ctrl;
	logic sw_wr_addr;
	logic sw_wr_data;
	logic sw_wr_mask;
	logic rd_status_clr;
	logic [7:0] ctrl_view;
	logic [31:0] read_word;
	logic [7:0] wdata_lo;

	// read-side register selects
	logic hit_ctrl;
	logic hit_addr;
	logic hit_data;
	logic hit_status;
	logic hit_mask;

	assign take = I_HSEL && I_HTRANS[`NVMAC_HTRANS_ACTIVE_BIT] && I_HREADY;
	assign take_wr = take && I_HWRITE;
	assign take_rd = take && !I_HWRITE;
	assign wdata_lo = I_HWDATA[7:0];

	// narrow writes are dropped so a half-word cannot half-start a cycle
	assign sw_wr_ctrl = wr_pend && wr_req_ph.word && reg_hit(wr_req_ph, `NVMAC_IDX_CONTROL);
	assign sw_wr_addr = wr_pend && wr_req_ph.word && reg_hit(wr_req_ph, `NVMAC_IDX_BYTE_ADDRESS);
	assign sw_wr_data = wr_pend && wr_req_ph.word && reg_hit(wr_req_ph, `NVMAC_IDX_BYTE_DATA);
	assign sw_wr_mask = wr_pend && wr_req_ph.word && reg_hit(wr_req_ph, `NVMAC_IDX_IRQ_MASK);
	assign rd_status_clr = rd_pend && hit_status;

	// low three bits are tied off in the view
	assign ctrl_view = {ctrl, 3'h0};

	// decoded once from the latched address phase
	assign hit_ctrl = reg_hit(rd_req_ph, `NVMAC_IDX_CONTROL);
	assign hit_addr = reg_hit(rd_req_ph, `NVMAC_IDX_BYTE_ADDRESS);
	assign hit_data = reg_hit(rd_req_ph, `NVMAC_IDX_BYTE_DATA);
	assign hit_status = reg_hit(rd_req_ph, `NVMAC_IDX_IRQ_STATUS);
	assign hit_mask = reg_hit(rd_req_ph, `NVMAC_IDX_IRQ_MASK);

	// unmapped offsets read as zero rather than aliasing a register
	always_comb begin
		read_word = 32'h00000000;
		if (hit_ctrl) begin
			read_word = {24'h000000, ctrl_view};
		end else if (hit_addr) begin
			read_word = {25'h0000000, byte_addr};
		end else if (hit_data) begin
			read_word = {24'h000000, byte_data};
		end else if (hit_status) begin
			read_word = {28'h0000000, irq_status};
		end else if (hit_mask) begin
			read_word = {28'h0000000, irq_mask};
		end
	end

	// operands latch on the idle-to-busy step
	assign start_op = (state == nvmac_pkg::NVMAC_IDLE) && (next_state != nvmac_pkg::NVMAC_IDLE);

	// register writes from software
	always_comb begin
		next_byte_addr = byte_addr;
		next_irq_mask = irq_mask;
		if (sw_wr_addr) begin
			next_byte_addr = wdata_lo[6:0];
		end
		if (sw_wr_mask) begin
			next_irq_mask = nvmac_pkg::nvmac_irq_t'(wdata_lo[3:0]);
		end
	end

	// engine and control register; hardware updates come last so they win
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_ctrl = ctrl;
		next_byte_data = byte_data;
		events = `NVMAC_IRQ_RESET;
		mem_we = 1'b0;
		mem_wdata = `NVMAC_ERASED_BYTE;
		if (sw_wr_ctrl) begin
			next_ctrl.write_enable_gate = wdata_lo[`NVMAC_BIT_WR_EN];
			next_ctrl.array_power_on = wdata_lo[`NVMAC_BIT_PWR];
			// request bits can only be set by software, never cleared
			if (wdata_lo[`NVMAC_BIT_RD_REQ]) begin
				next_ctrl.rd_req = 1'b1;
			end
			if (wdata_lo[`NVMAC_BIT_WR_REQ]) begin
				next_ctrl.wr_req = 1'b1;
			end
		end
		// data register is not touched by software while a read is fetching
		if (sw_wr_data && (state != nvmac_pkg::NVMAC_READ)) begin
			next_byte_data = wdata_lo;
		end
		case (state)
			nvmac_pkg::NVMAC_IDLE: begin
				// no mode gating: a request is served whenever idle
				if (ctrl.rd_req) begin
					if (ctrl.array_power_on) begin
						next_state = nvmac_pkg::NVMAC_READ;
						next_cnt = 8'(`NVMAC_READ_CYC - 1);
					end else begin
						next_ctrl.rd_req = 1'b0;
						events.pwr_refused = 1'b1;
					end
				end else if (ctrl.wr_req) begin
					if (!ctrl.array_power_on) begin
						next_ctrl.wr_req = 1'b0;
						events.pwr_refused = 1'b1;
					end else if (!ctrl.write_enable_gate) begin
						// array left alone, done-detect never rises
						next_ctrl.wr_req = 1'b0;
						events.wr_refused = 1'b1;
					end else begin
						next_state = nvmac_pkg::NVMAC_ERASE;
						next_cnt = 8'(`NVMAC_ERASE_CYC - 1);
						next_ctrl.done_detect = 1'b1;
					end
				end
			end
			nvmac_pkg::NVMAC_READ: begin
				if (cnt == 8'h00) begin
					next_byte_data = array_mem[op_addr];
					next_ctrl.rd_req = 1'b0;
					events.rd_done = 1'b1;
					next_state = nvmac_pkg::NVMAC_IDLE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			nvmac_pkg::NVMAC_ERASE: begin
				if (cnt == 8'h00) begin
					mem_we = 1'b1;
					mem_wdata = `NVMAC_ERASED_BYTE;
					next_state = nvmac_pkg::NVMAC_PROGRAM;
					next_cnt = 8'(`NVMAC_PROG_CYC - 1);
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			nvmac_pkg::NVMAC_PROGRAM: begin
				if (cnt == 8'h00) begin
					mem_we = 1'b1;
					// cells only clear bits when programmed, so a skipped erase shows up
					mem_wdata = array_mem[op_addr] & op_data;
					next_ctrl.wr_req = 1'b0;
					next_ctrl.done_detect = 1'b0;
					events.wr_done = 1'b1;
					next_state = nvmac_pkg::NVMAC_IDLE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			default: begin
				next_state = nvmac_pkg::NVMAC_IDLE;
			end
		endcase
	end

	// read clears only what was reported; a same-cycle event still lands
	always_comb begin
		next_irq_status = irq_status;
		if (rd_status_clr) begin
			next_irq_status = `NVMAC_IRQ_RESET;
		end
		next_irq_status = next_irq_status | events;
	end

	// bus pipeline: writes are zero-wait, reads insert one wait state
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_req_ph <= '0;
			rd_req_ph <= '0;
		end else begin
			wr_pend <= take_wr;
			rd_pend <= take_rd;
			if (take) begin
				wr_req_ph <= decode_req(I_HADDR, I_HSIZE);
				rd_req_ph <= decode_req(I_HADDR, I_HSIZE);
			end
		end
	end

	// the wait state lets a write in the previous data phase settle first
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_HRDATA <= 32'h00000000;
			O_HREADYOUT <= 1'b1;
			O_HRESP <= `NVMAC_HRESP_OKAY;
		end else begin
			O_HREADYOUT <= !take_rd;
			O_HRESP <= `NVMAC_HRESP_OKAY;
			if (rd_pend) begin
				O_HRDATA <= read_word;
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ctrl <= `NVMAC_CTRL_RESET;
			byte_addr <= `NVMAC_ADDR_RESET;
			byte_data <= `NVMAC_DATA_RESET;
			state <= nvmac_pkg::NVMAC_IDLE;
			cnt <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			byte_addr <= next_byte_addr;
			byte_data <= next_byte_data;
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// operands frozen at start so late register writes cannot corrupt a cycle
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			op_addr <= `NVMAC_ADDR_RESET;
			op_data <= `NVMAC_DATA_RESET;
		end else if (start_op) begin
			op_addr <= byte_addr;
			op_data <= byte_data;
		end
	end

	// array model in flip-flops; reset leaves it in the erased state
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			for (int i = 0; i < 128; i++) begin
				array_mem[i] <= `NVMAC_ERASED_BYTE;
			end
		end else if (mem_we) begin
			array_mem[op_addr] <= mem_wdata;
		end
	end

	// irq follows the next status so it moves on the same edge as the flag
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_status <= `NVMAC_IRQ_RESET;
			irq_mask <= `NVMAC_IRQ_RESET;
			O_IRQ <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			O_IRQ <= |(next_irq_status & next_irq_mask);
		end
	end

endmodule

`default_nettype wire
